// >>> rtl/ocsc_delay_timer.sv
`timescale 1ns/1ps
`include "ocsc_regs.svh"

module ocsc_delay_timer #(
    parameter int TICK_CYCLES = `OCSC_TICK_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       start,
    input  wire logic       stop,
    input  wire logic [2:0] sel,
    output logic            expire
);
    logic [11:0] pre_ff;
    logic        tick_ff;
    logic        run_ff;
    logic [11:0] us_ff;
    logic [11:0] limit_ff;

    function automatic logic [11:0] delay_us(input logic [2:0] code);
        case (code)
            3'h2:    delay_us = 12'(`OCSC_DLY_128US);
            3'h3:    delay_us = 12'(`OCSC_DLY_256US);
            3'h4:    delay_us = 12'(`OCSC_DLY_512US);
            3'h5:    delay_us = 12'(`OCSC_DLY_1MS_US);
            3'h6:    delay_us = 12'(`OCSC_DLY_2MS_US);
            3'h7:    delay_us = 12'(`OCSC_DLY_4MS_US);
            default: delay_us = 12'(`OCSC_DLY_32US);
        endcase
    endfunction

    // Microsecond tick enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_ff  <= 12'h000;
            tick_ff <= 1'b0;
        end else if (start || pre_ff == 12'(TICK_CYCLES - 1)) begin
            pre_ff  <= 12'h000;
            tick_ff <= !start;
        end else begin
            pre_ff  <= pre_ff + 12'h001;
            tick_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_ff   <= 1'b0;
            us_ff    <= 12'h000;
            limit_ff <= 12'h000;
            expire   <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (start) begin
                run_ff   <= 1'b1;
                us_ff    <= 12'h000;
                limit_ff <= delay_us(sel);
            end else if (stop) begin
                run_ff <= 1'b0;
            end else if (run_ff && tick_ff) begin
                us_ff <= us_ff + 12'h001;
                if (us_ff + 12'h001 == limit_ff) begin
                    run_ff <= 1'b0;
                    expire <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> rtl/ocsc_pkg.sv
package ocsc_pkg;
    typedef enum logic [2:0] {
        FK_INFORM,
        FK_LOOP_START,
        FK_LOOP_STOP,
        FK_REMOTE,
        FK_INDICATE
    } ocsc_frame_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_WAIT
    } ocsc_state_t;
endpackage

// >>> rtl/ocsc_regs.svh
`ifndef OCSC_REGS_SVH
`define OCSC_REGS_SVH

// Register offsets
`define OCSC_OFS_PHY_ADDR      8'h40
`define OCSC_OFS_STATE         8'h41
`define OCSC_OFS_CMD           8'h42

// Center side state fields
`define OCSC_ST_BUSY_BIT       7
`define OCSC_ST_VENDOR_BIT     6
`define OCSC_ST_OPTB_BIT       2
`define OCSC_ST_OPTA_BIT       1
`define OCSC_ST_REQ_BIT        0

// Command register fields
`define OCSC_CMD_DELAY_HI      7
`define OCSC_CMD_DELAY_LO      5
`define OCSC_CMD_CODE_HI       4
`define OCSC_CMD_CODE_LO       0

// Reset values and reserved delay code
`define OCSC_PHY_ADDR_RST      5'h01
`define OCSC_DELAY_RST         3'h1
`define OCSC_DELAY_BAD         3'h0

// Accepted fiber port addresses and fixed addresses
`define OCSC_ADDR_A            5'h01
`define OCSC_ADDR_B            5'h03
`define OCSC_PORT1_FIXED       5'h01
`define OCSC_PORT2_FIXED       5'h02

// Command codes
`define OCSC_CODE_NONE         5'h00
`define OCSC_CODE_INFORM       5'h01
`define OCSC_CODE_LOOP_START   5'h02
`define OCSC_CODE_LOOP_STOP    5'h04
`define OCSC_CODE_REMOTE       5'h08
`define OCSC_CODE_INDICATE     5'h10

// Mode select pin patterns {hi, lo}
`define OCSC_MODE_CENTER       2'b01
`define OCSC_MODE_TERMINAL     2'b10

// Timing
`define OCSC_CLK_MHZ           250
`define OCSC_TICK_US           1
`define OCSC_TICK_CYC          (`OCSC_TICK_US * `OCSC_CLK_MHZ)
`define OCSC_DLY_32US          32
`define OCSC_DLY_128US         128
`define OCSC_DLY_256US         256
`define OCSC_DLY_512US         512
`define OCSC_DLY_1MS_US        1000
`define OCSC_DLY_2MS_US        2000
`define OCSC_DLY_4MS_US        4000

`endif

// >>> rtl/ocsc_top.sv
`timescale 1ns/1ps
`include "ocsc_regs.svh"

module ocsc_top #(
    parameter int TICK_CYCLES = `OCSC_TICK_CYC
) (
    input  wire logic                 CLK,
    input  wire logic                 RST_B,
    input  wire logic                 MAINT_MODE_SEL_HI,
    input  wire logic                 MAINT_MODE_SEL_LO,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    input  wire logic [7:0]           REG_ADDR,
    input  wire logic [7:0]           REG_WDATA,
    output logic      [7:0]           REG_RDATA,
    input  wire logic                 WATCH_CHANGE,
    input  wire logic                 REMOTE_CMD_EN,
    input  wire logic                 LOOP_RUN,
    input  wire logic                 COND_CHANGE,
    input  wire logic                 FRAME_ACK,
    input  wire logic                 REPLY_RX,
    output logic                      FRAME_REQ,
    output ocsc_pkg::ocsc_frame_t     FRAME_KIND,
    output logic                      MODEL_INFO_ALT,
    output logic                      TIMEOUT,
    output logic      [4:0]           PORT1_PHY_ADDR,
    output logic      [4:0]           PORT2_PHY_ADDR,
    output logic                      PORT2_MIIM_EN,
    output logic                      PORT1_ENABLE,
    output logic                      CENTER_MC_RUN,
    output logic                      VENDOR_SPECIAL,
    output logic                      CLEAR_TERM_STATUS,
    output logic                      IND_FRAME_EN
);
    import ocsc_pkg::*;

    logic [1:0]  pin_s1_ff;
    logic [1:0]  pin_s2_ff;
    logic [4:0]  fiber_addr_field_ff;
    logic        center_run_ff;
    logic        vendor_ff;
    logic        opt_b_ff;
    logic        opt_a_ff;
    logic        req_ff;
    logic [2:0]  delay_ff;
    logic [4:0]  frame_command_field_ff;
    logic        ind_pend_ff;
    ocsc_state_t state_ff;
    ocsc_state_t nxt_state;
    ocsc_frame_t kind_ff;
    logic        need_reply_ff;
    logic        center_w;
    logic        terminal_w;
    logic        busy_w;
    logic        wr_phy;
    logic        wr_stat;
    logic        wr_cmd;
    logic        rd_stat;
    logic        addr_ok;
    logic        ind_go;
    logic        cmd_take;
    logic        cmd_ok;
    ocsc_frame_t cmd_kind;
    logic        cmd_clr;
    logic        tmr_start;
    logic        tmr_stop;
    logic        tmr_expire;

    function automatic logic mode_is(input logic [1:0] pins, input logic [1:0] pat);
        mode_is = (pins == pat);
    endfunction

    // Mode pin synchroniser
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_s1_ff <= 2'h0;
            pin_s2_ff <= 2'h0;
        end else begin
            pin_s1_ff <= {MAINT_MODE_SEL_HI, MAINT_MODE_SEL_LO};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    assign center_w   = mode_is(pin_s2_ff, `OCSC_MODE_CENTER);
    assign terminal_w = mode_is(pin_s2_ff, `OCSC_MODE_TERMINAL);

    assign wr_phy  = REG_WR && REG_ADDR == `OCSC_OFS_PHY_ADDR;
    assign wr_stat = REG_WR && REG_ADDR == `OCSC_OFS_STATE;
    assign wr_cmd  = REG_WR && REG_ADDR == `OCSC_OFS_CMD;
    assign rd_stat = REG_RD && REG_ADDR == `OCSC_OFS_STATE;
    assign addr_ok = REG_WDATA[4:0] == `OCSC_ADDR_A || REG_WDATA[4:0] == `OCSC_ADDR_B;

    // Fiber port address and center start
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            fiber_addr_field_ff <= `OCSC_PHY_ADDR_RST;
        end else if (wr_phy && addr_ok) begin
            fiber_addr_field_ff <= REG_WDATA[4:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            center_run_ff <= 1'b0;
        end else if (!center_w) begin
            center_run_ff <= 1'b0;
        end else if (wr_phy && addr_ok) begin
            center_run_ff <= 1'b1;
        end
    end

    // Management bus port map
    assign PORT1_PHY_ADDR = center_w ? fiber_addr_field_ff : `OCSC_PORT1_FIXED;
    assign PORT2_PHY_ADDR = `OCSC_PORT2_FIXED;
    assign PORT2_MIIM_EN  = !center_w;
    assign PORT1_ENABLE   = !center_w || center_run_ff;
    assign CENTER_MC_RUN  = center_w && center_run_ff;

    // Center side state register
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            vendor_ff <= 1'b0;
            opt_b_ff  <= 1'b0;
            opt_a_ff  <= 1'b0;
        end else if (wr_stat) begin
            vendor_ff <= REG_WDATA[`OCSC_ST_VENDOR_BIT];
            opt_b_ff  <= REG_WDATA[`OCSC_ST_OPTB_BIT];
            opt_a_ff  <= REG_WDATA[`OCSC_ST_OPTA_BIT];
        end
    end

    assign VENDOR_SPECIAL    = !vendor_ff;
    assign CLEAR_TERM_STATUS = opt_b_ff;
    assign IND_FRAME_EN      = !opt_a_ff;

    // Change request flag, set wins over read clear
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            req_ff <= 1'b0;
        end else if (WATCH_CHANGE) begin
            req_ff <= 1'b1;
        end else if (rd_stat) begin
            req_ff <= 1'b0;
        end
    end

    // Command register
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            delay_ff <= `OCSC_DELAY_RST;
        end else if (wr_cmd && REG_WDATA[7:5] != `OCSC_DELAY_BAD) begin
            delay_ff <= REG_WDATA[`OCSC_CMD_DELAY_HI:`OCSC_CMD_DELAY_LO];
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            frame_command_field_ff <= `OCSC_CODE_NONE;
        end else if (wr_cmd) begin
            frame_command_field_ff <= REG_WDATA[`OCSC_CMD_CODE_HI:`OCSC_CMD_CODE_LO];
        end else if (cmd_clr) begin
            frame_command_field_ff <= `OCSC_CODE_NONE;
        end
    end

    // Command decode
    always_comb begin
        cmd_ok    = 1'b0;
        cmd_kind  = FK_INFORM;
        case (frame_command_field_ff)
            `OCSC_CODE_INFORM: begin
                cmd_ok = center_run_ff;
            end
            `OCSC_CODE_LOOP_START: begin
                cmd_ok   = center_run_ff;
                cmd_kind = FK_LOOP_START;
            end
            `OCSC_CODE_LOOP_STOP: begin
                cmd_ok   = center_run_ff;
                cmd_kind = FK_LOOP_STOP;
            end
            `OCSC_CODE_REMOTE: begin
                cmd_ok   = center_run_ff && REMOTE_CMD_EN;
                cmd_kind = FK_REMOTE;
            end
            default: begin
                cmd_ok = 1'b0;
            end
        endcase
    end

    assign ind_go   = state_ff == ST_IDLE && ind_pend_ff && !opt_a_ff;
    assign cmd_take = state_ff == ST_IDLE && !ind_go
                      && frame_command_field_ff != `OCSC_CODE_NONE;
    assign cmd_clr  = cmd_take;

    // Indication pending, set wins over dispatch
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ind_pend_ff <= 1'b0;
        end else if (COND_CHANGE
                     || (cmd_take && frame_command_field_ff == `OCSC_CODE_INDICATE)) begin
            ind_pend_ff <= 1'b1;
        end else if (ind_go || opt_a_ff) begin
            ind_pend_ff <= 1'b0;
        end
    end

    // Frame dispatch state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (ind_go || (cmd_take && cmd_ok)) begin
                    nxt_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (FRAME_ACK) begin
                    nxt_state = need_reply_ff ? ST_WAIT : ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (REPLY_RX || tmr_expire) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            kind_ff       <= FK_INFORM;
            need_reply_ff <= 1'b0;
        end else if (ind_go) begin
            kind_ff       <= FK_INDICATE;
            need_reply_ff <= 1'b0;
        end else if (cmd_take && cmd_ok) begin
            kind_ff       <= cmd_kind;
            need_reply_ff <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            TIMEOUT <= 1'b0;
        end else begin
            TIMEOUT <= state_ff == ST_WAIT && tmr_expire && !REPLY_RX;
        end
    end

    assign FRAME_REQ      = state_ff == ST_SEND;
    assign FRAME_KIND     = kind_ff;
    assign MODEL_INFO_ALT = kind_ff == FK_REMOTE;
    assign busy_w         = LOOP_RUN || (state_ff != ST_IDLE && need_reply_ff);

    assign tmr_start = state_ff == ST_SEND && FRAME_ACK && need_reply_ff;
    assign tmr_stop  = state_ff == ST_WAIT && REPLY_RX;

    ocsc_delay_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk    (CLK),
        .rst_b  (RST_B),
        .start  (tmr_start),
        .stop   (tmr_stop),
        .sel    (delay_ff),
        .expire (tmr_expire)
    );

    // Register read port
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `OCSC_OFS_PHY_ADDR: REG_RDATA <= {3'h0, fiber_addr_field_ff};
                `OCSC_OFS_STATE: begin
                    REG_RDATA <= {busy_w, vendor_ff, 3'h0, opt_b_ff, opt_a_ff, req_ff};
                end
                `OCSC_OFS_CMD: REG_RDATA <= {delay_ff, frame_command_field_ff};
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    addr_filter_a: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_phy && !addr_ok |=> $stable(fiber_addr_field_ff))
        else $error("bad fiber address stored");

    term_addr_a: assert property (@(posedge CLK) disable iff (!RST_B)
        terminal_w |-> PORT1_PHY_ADDR == `OCSC_PORT1_FIXED)
        else $error("terminal port 1 address not fixed");

    center_start_a: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(center_run_ff) |-> $past(wr_phy && addr_ok && center_w))
        else $error("center started without address write");

    port_map_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !center_w |-> PORT2_MIIM_EN && PORT2_PHY_ADDR == `OCSC_PORT2_FIXED
                      && PORT1_PHY_ADDR == `OCSC_PORT1_FIXED)
        else $error("port map wrong outside center mode");

    busy_read_a: assert property (@(posedge CLK) disable iff (!RST_B)
        rd_stat && state_ff == ST_WAIT |=> REG_RDATA[`OCSC_ST_BUSY_BIT])
        else $error("busy not shown while reply pending");

    req_flag_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (WATCH_CHANGE |=> req_ff) and (rd_stat && !WATCH_CHANGE |=> !req_ff))
        else $error("request flag wrong");

    delay_keep_a: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_cmd && REG_WDATA[7:5] == `OCSC_DELAY_BAD |=> $stable(delay_ff))
        else $error("reserved delay code stored");

    ind_suppress_a: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(FRAME_REQ) && FRAME_KIND == FK_INDICATE |-> !$past(opt_a_ff))
        else $error("indication sent while suppressed");

    side_gate_a: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(FRAME_REQ) && FRAME_KIND != FK_INDICATE |-> $past(center_run_ff))
        else $error("command frame sent off center side");

    remote_gate_a: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(FRAME_REQ) && FRAME_KIND == FK_REMOTE |-> $past(REMOTE_CMD_EN) && MODEL_INFO_ALT)
        else $error("remote command sent while disabled");

    cmd_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
        cmd_take && !wr_cmd |=> frame_command_field_ff == `OCSC_CODE_NONE)
        else $error("command field not returned to idle");

    timeout_a: assert property (@(posedge CLK) disable iff (!RST_B)
        TIMEOUT |-> state_ff == ST_IDLE && $past(state_ff == ST_WAIT))
        else $error("timeout outside reply wait");
endmodule

// >>> tb/ocsc_far_end.sv
`timescale 1ns/1ps

module ocsc_far_end (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  frame_req,
    input  wire ocsc_pkg::ocsc_frame_t frame_kind,
    input  wire logic                  reply_en,
    input  wire logic [3:0]            ack_dly,
    output logic                       frame_ack,
    output logic                       reply_rx,
    output int                         frame_cnt
);
    import ocsc_pkg::*;

    int wait_cnt;
    int rep_cnt;

    // Acks each request after ack_dly cycles, replies 3 cycles later when reply_en is set, except to indication frames
    always @(negedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_ack <= 1'b0;
            reply_rx  <= 1'b0;
            wait_cnt  <= 0;
            rep_cnt   <= 0;
            frame_cnt <= 0;
        end else begin
            frame_ack <= 1'b0;
            reply_rx  <= 1'b0;
            if (frame_req && !frame_ack) begin
                if (wait_cnt >= int'(ack_dly)) begin
                    frame_ack <= 1'b1;
                    wait_cnt  <= 0;
                    frame_cnt <= frame_cnt + 1;
                    if (reply_en && frame_kind != FK_INDICATE) begin
                        rep_cnt <= 3;
                    end
                end else begin
                    wait_cnt <= wait_cnt + 1;
                end
            end
            if (rep_cnt == 1) begin
                reply_rx <= 1'b1;
            end
            if (rep_cnt > 0) begin
                rep_cnt <= rep_cnt - 1;
            end
        end
    end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import ocsc_pkg::*;

    logic        clk      = 1'b0;
    logic        rst_b    = 1'b0;
    logic        sel_hi   = 1'b0;
    logic        sel_lo   = 1'b0;
    logic        wr_s     = 1'b0;
    logic        rd_s     = 1'b0;
    logic [7:0]  addr     = 8'h00;
    logic [7:0]  wdata    = 8'h00;
    logic        watch    = 1'b0;
    logic        rc_en    = 1'b0;
    logic        loop_run = 1'b0;
    logic        cond     = 1'b0;
    logic        reply_en = 1'b1;
    logic [7:0]  rdata;
    logic        ack;
    logic        reply;
    logic        freq;
    ocsc_frame_t fkind;
    logic        alt;
    logic        tmo;
    logic [4:0]  p1_addr;
    logic [4:0]  p2_addr;
    logic        p2_en;
    logic        p1_en;
    logic        mc_run;
    logic        vend_sp;
    logic        clr_ts;
    logic        ind_en;
    int          fcnt;
    int          err_count = 0;
    int          cmp_count = 0;
    int          cyc       = 0;

    always #2 clk = ~clk;

    ocsc_top #(.TICK_CYCLES(2)) i_ocsc_top (
        .CLK(clk), .RST_B(rst_b), .MAINT_MODE_SEL_HI(sel_hi), .MAINT_MODE_SEL_LO(sel_lo),
        .REG_WR(wr_s), .REG_RD(rd_s), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .WATCH_CHANGE(watch), .REMOTE_CMD_EN(rc_en),
        .LOOP_RUN(loop_run), .COND_CHANGE(cond), .FRAME_ACK(ack), .REPLY_RX(reply),
        .FRAME_REQ(freq), .FRAME_KIND(fkind), .MODEL_INFO_ALT(alt), .TIMEOUT(tmo),
        .PORT1_PHY_ADDR(p1_addr), .PORT2_PHY_ADDR(p2_addr), .PORT2_MIIM_EN(p2_en),
        .PORT1_ENABLE(p1_en), .CENTER_MC_RUN(mc_run), .VENDOR_SPECIAL(vend_sp),
        .CLEAR_TERM_STATUS(clr_ts), .IND_FRAME_EN(ind_en)
    );

    ocsc_far_end i_ocsc_far_end (
        .clk(clk), .rst_b(rst_b), .frame_req(freq), .frame_kind(fkind),
        .reply_en(reply_en), .ack_dly(4'h2), .frame_ack(ack), .reply_rx(reply),
        .frame_cnt(fcnt)
    );

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // All bus tasks start and end just after a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr  = a;
        wdata = d;
        wr_s  = 1'b1;
        @(negedge clk);
        wr_s  = 1'b0;
        @(negedge clk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk);
        rd_s = 1'b0;
        chk(rdata, exp);
        @(negedge clk);
    endtask

    task automatic frame(input ocsc_frame_t k, input logic a);
        int j;
        for (j = 0; j < 20 && freq !== 1'b1; j++) @(negedge clk);
        chk({3'h0, freq, alt, fkind}, {3'h0, 1'b1, a, k});
        for (j = 0; j < 20 && freq === 1'b1; j++) @(negedge clk);
    endtask

    task automatic quiet(input int n);
        repeat (20) @(negedge clk);
        chk(8'(fcnt), 8'(n));
    endtask

    task automatic t_reset;
        rchk(8'h40, 8'h01);
        rchk(8'h41, 8'h00);
        rchk(8'h42, 8'h20);
        rchk(8'h77, 8'h00);
        chk({2'h0, p2_en, p1_addr}, 8'h21);
        chk({3'h0, p2_addr}, 8'h02);
        chk({7'h0, vend_sp}, 8'h01);
        wr(8'h42, 8'h30);
        frame(FK_INDICATE, 1'b0);
        rchk(8'h41, 8'h00);
        rchk(8'h42, 8'h20);
        $display("test reset done");
    endtask

    task automatic t_center;
        sel_lo = 1'b1;
        repeat (4) @(negedge clk);
        chk({5'h0, p1_en, p2_en, mc_run}, 8'h00);
        wr(8'h40, 8'h05);
        rchk(8'h40, 8'h01);
        chk({7'h0, p1_en}, 8'h00);
        wr(8'h40, 8'h03);
        rchk(8'h40, 8'h03);
        chk({1'h0, mc_run, p1_addr, p1_en}, 8'h47);
        $display("test center done");
    endtask

    task automatic t_cmds;
        logic [4:0]  codes [4] = '{5'h01, 5'h02, 5'h04, 5'h08};
        ocsc_frame_t kinds [4] = '{FK_INFORM, FK_LOOP_START, FK_LOOP_STOP, FK_REMOTE};
        int          n;
        n = fcnt;
        wr(8'h42, 8'h28);
        quiet(n);
        wr(8'h42, 8'h23);
        quiet(n);
        rchk(8'h42, 8'h20);
        rc_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(8'h42, {3'h1, codes[i]});
            frame(kinds[i], i == 3);
            repeat (6) @(negedge clk);
            rchk(8'h41, 8'h00);
            rchk(8'h42, 8'h20);
        end
        $display("test commands done");
    endtask

    task automatic t_timeout;
        logic [2:0] dsel [3] = '{3'h1, 3'h2, 3'h3};
        int         dexp [3] = '{64, 256, 512};
        int         j;
        reply_en = 1'b0;
        for (int i = 0; i < 3; i++) begin
            wr(8'h42, {dsel[i], 5'h01});
            frame(FK_INFORM, 1'b0);
            rchk(8'h41, 8'h80);
            for (j = 0; j < 700 && tmo !== 1'b1; j++) @(negedge clk);
            chk(8'(j > dexp[i] - 10 && j < dexp[i] + 6), 8'h01);
            @(negedge clk);
            rchk(8'h41, 8'h00);
        end
        wr(8'h42, 8'h00);
        rchk(8'h42, 8'h60);
        reply_en = 1'b1;
        $display("test timeout done");
    endtask

    task automatic t_status;
        int n;
        wr(8'h41, 8'hff);
        rchk(8'h41, 8'h46);
        chk({5'h0, vend_sp, clr_ts, ind_en}, 8'h02);
        n = fcnt;
        cond = 1'b1;
        @(negedge clk);
        cond = 1'b0;
        quiet(n);
        watch = 1'b1;
        @(negedge clk);
        watch = 1'b0;
        rchk(8'h41, 8'h47);
        rchk(8'h41, 8'h46);
        loop_run = 1'b1;
        repeat (3) @(negedge clk);
        rchk(8'h41, 8'hc6);
        loop_run = 1'b0;
        wr(8'h41, 8'h00);
        chk({5'h0, vend_sp, clr_ts, ind_en}, 8'h05);
        cond = 1'b1;
        @(negedge clk);
        cond = 1'b0;
        frame(FK_INDICATE, 1'b0);
        $display("test status done");
    endtask

    task automatic t_terminal;
        int n;
        sel_hi = 1'b1;
        sel_lo = 1'b0;
        repeat (4) @(negedge clk);
        chk({1'h0, mc_run, p2_en, p1_addr}, 8'h21);
        chk({3'h0, p2_addr}, 8'h02);
        n = fcnt;
        wr(8'h42, 8'h21);
        quiet(n);
        $display("test terminal done");
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_reset();
        t_center();
        t_cmds();
        t_timeout();
        t_status();
        t_terminal();
        end_of_test();
    end
endmodule
